/* bsp_ctrl_model.sv */
module bsp_ctrl_model #(
    parameter int AW = 19,
    parameter int DW = 36
) (
    input  wire logic          mclk,    // clock
    output logic               sel1_n,  // select one
    output logic               sel2,    // select two
    output logic               sel3_n,  // select three
    output logic               ps_n,    // processor strobe
    output logic               cs_n,    // controller strobe
    output logic               step_n,  // burst advance
    output logic               all_n,   // write all lanes
    output logic               gate_n,  // lane write gate
    output logic [3:0]         lane_n,  // lane enables
    output logic [AW-1:0]      addr,    // address
    output logic [DW-1:0]      wdata    // write data
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----
    // one command per cycle, launched just after the edge
    // ----
    initial begin
        {sel1_n, sel2, sel3_n, ps_n, cs_n, step_n} = 6'h35;
        {all_n, gate_n, lane_n, addr, wdata} = '1;
    end

    // kind: 0 idle, 1 proc begin, 2 ctrl begin, 3 next, 4 hold, 5 deselect
    task automatic cmd(input int k, input bit wr, input bit all, input logic [3:0] ln,
                       input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge mclk);
        sel1_n <= (k == 0);
        sel2   <= (k != 5);
        sel3_n <= 1'b0;
        ps_n   <= !(k == 1 || k == 5);
        cs_n   <= !(k == 0 || k == 2);
        step_n <= (k != 3);
        all_n  <= !(wr && all);
        gate_n <= !(wr && !all);
        lane_n <= ln;
        addr   <= a;
        // released data lines never keep the last value
        wdata  <= wr ? d : ~wdata;
    endtask
endmodule

/* bsp_pkg.sv */
package bsp_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL        = 4'h0;
    localparam logic [3:0] OFS_STATUS      = 4'h4;
    localparam int         CTRL_STANDBY    = 0;
    localparam int         ST_SLEEP        = 0;
    localparam int         ST_PIPE         = 1;
    localparam int         ST_INTLV        = 2;
    localparam int         ST_OP_LSB       = 3;
    localparam int         ST_STEP_LSB     = 6;
    localparam int         ST_LO_LSB       = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic       RST_STANDBY     = 1'b0;
    localparam logic       RST_OUT_DIS     = 1'b1;
    localparam logic       RST_PIPE        = 1'b1;
    localparam logic       RST_INTLV       = 1'b1;
    localparam logic       RST_SLEEP       = 1'b0;
    localparam logic       RST_WAITREQ     = 1'b1;

    // ------------------------------------------------------------
    // operation decoded each edge
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE     = 3'h0,
        OP_DESEL    = 3'h1,
        OP_BEGIN_RD = 3'h2,
        OP_BEGIN_WR = 3'h3,
        OP_NEXT_RD  = 3'h4,
        OP_NEXT_WR  = 3'h5,
        OP_HOLD_RD  = 3'h6,
        OP_HOLD_WR  = 3'h7
    } bsp_op_t;

endpackage

/* bsp_top.sv */
// Functional notes
// - selects off with strobe low means deselect; processor strobe is ignored while select one is off
// - enabled, processor strobe low: begin read
// - controller strobe alone begins read or write
// - step low continues burst at next address
// - step high repeats current address
// - four-address counter, linear or interleaved, wraps
// - global write all lanes, gate uses enables
// - any lane combination written in one cycle
// - reads drive every byte lane
// - writes keep all lanes undriven
// - lanes c and d only in wide organisations
// - output enable high turns drivers off
// - dummy read advances counter like read
// - flow-through select low bypasses output register
// - sleep high standby; order pin picks sequence
// - low address bits preset burst counter
module bsp_top #(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 36,
    parameter int LANES  = 4
) (
    input  wire logic              mclk,             // clock
    input  wire logic              arst_n,           // async reset
    input  wire logic              ce,               // clock enable
    input  wire logic              chip_sel_one_n,   // select one
    input  wire logic              chip_sel_two,     // select two
    input  wire logic              chip_sel_three_n, // select three
    input  wire logic              proc_addr_strobe_n, // processor strobe
    input  wire logic              ctrl_addr_strobe_n, // controller strobe
    input  wire logic              burst_step_n,     // burst advance
    input  wire logic [ADDR_W-1:2] addr_high,        // upper address
    input  wire logic [1:0]        addr_low_bits,    // counter preset
    input  wire logic              all_bytes_write_n, // write all lanes
    input  wire logic              lane_write_gate_n, // lane write gate
    input  wire logic              byte_lane_a_n,    // lane a enable
    input  wire logic              byte_lane_b_n,    // lane b enable
    input  wire logic              byte_lane_c_n,    // lane c enable
    input  wire logic              byte_lane_d_n,    // lane d enable
    input  wire logic              out_enable_n,     // async output enable
    input  wire logic              sleep_req,        // standby request
    input  wire logic              flowthru_sel_n,   // flow-through select
    input  wire logic              linear_order_n,   // burst order
    input  wire logic [DATA_W-1:0] dq_i,             // data in
    output logic      [DATA_W-1:0] dq_o,             // data out
    output logic      [LANES-1:0]  dq_oe,            // lane drive enable
    input  wire logic [3:0]        avs_address,      // bus byte address
    input  wire logic              avs_read,         // bus read
    input  wire logic              avs_write,        // bus write
    input  wire logic [31:0]       avs_writedata,    // bus write data
    output logic      [31:0]       avs_readdata,     // bus read data
    output logic                   avs_waitrequest   // bus wait
);

    localparam int LW = DATA_W / LANES;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]        oe_s;
        logic [2:0]        sleep_s;
        logic [2:0]        flow_s;
        logic [2:0]        order_s;
        logic              oe_f;
        logic              sleep_f;
        logic              flow_f;
        logic              order_f;
        logic [ADDR_W-3:0] hi;
        logic [1:0]        start;
        logic [1:0]        step;
        logic [1:0]        lo;
        bsp_pkg::bsp_op_t  op;
        logic              pv;
        logic [DATA_W-1:0] pdata;
        logic [DATA_W-1:0] dq_o;
        logic [LANES-1:0]  dq_oe;
        logic              standby;
        logic              waitreq;
        logic [31:0]       rdata;
    } bsp_state_t;

    bsp_state_t        q;
    bsp_state_t        d;
    logic [1:0]        rst_sync_q;
    logic              rst_n;
    logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] burst_lo(input logic [1:0] s,
                                            input logic [1:0] n,
                                            input logic       intlv);
        burst_lo = intlv ? (s ^ n) : 2'(s + n);
    endfunction

    function automatic logic filt(input logic [2:0] s, input logic f);
        filt = (s[2] == s[1]) ? s[1] : f;
    endfunction

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic              sel_ok;
    logic              desel;
    logic              wr_cond;
    logic              sleep_eff;
    logic [3:0]        lane_n;
    logic [LANES-1:0]  lane_we;
    bsp_pkg::bsp_op_t  op_now;
    logic              is_rd;
    logic              is_wr;
    logic [ADDR_W-3:0] hi_now;
    logic [1:0]        start_now;
    logic [1:0]        step_now;
    logic [1:0]        lo_now;
    logic [DATA_W-1:0] rd_word;

    assign sel_ok    = !chip_sel_one_n && chip_sel_two && !chip_sel_three_n;
    assign desel     = (!chip_sel_one_n && (!chip_sel_two || chip_sel_three_n)
                       && (!proc_addr_strobe_n || !ctrl_addr_strobe_n))
                       || (chip_sel_one_n && !ctrl_addr_strobe_n);
    assign wr_cond   = !all_bytes_write_n || !lane_write_gate_n;
    assign sleep_eff = q.sleep_f || q.standby;
    assign lane_n    = {byte_lane_d_n, byte_lane_c_n, byte_lane_b_n, byte_lane_a_n};

    always_comb begin
        if (!all_bytes_write_n) begin
            lane_we = '1;
        end else if (!lane_write_gate_n) begin
            lane_we = ~lane_n[LANES-1:0];
        end else begin
            lane_we = '0;
        end
    end

    always_comb begin
        if (sleep_eff) begin
            op_now = bsp_pkg::OP_NONE;
        end else if (desel) begin
            op_now = bsp_pkg::OP_DESEL;
        end else if (sel_ok && !proc_addr_strobe_n) begin
            op_now = bsp_pkg::OP_BEGIN_RD;
        end else if (sel_ok && !ctrl_addr_strobe_n) begin
            op_now = wr_cond ? bsp_pkg::OP_BEGIN_WR : bsp_pkg::OP_BEGIN_RD;
        end else if (!burst_step_n) begin
            op_now = wr_cond ? bsp_pkg::OP_NEXT_WR : bsp_pkg::OP_NEXT_RD;
        end else begin
            op_now = wr_cond ? bsp_pkg::OP_HOLD_WR : bsp_pkg::OP_HOLD_RD;
        end
    end

    always_comb begin
        hi_now    = q.hi;
        start_now = q.start;
        step_now  = q.step;
        case (op_now)
            bsp_pkg::OP_BEGIN_RD, bsp_pkg::OP_BEGIN_WR: begin
                hi_now    = addr_high;
                start_now = addr_low_bits;
                step_now  = 2'h0;
            end
            bsp_pkg::OP_NEXT_RD, bsp_pkg::OP_NEXT_WR: begin
                step_now  = 2'(q.step + 2'h1);
            end
            default: begin
                step_now  = q.step;
            end
        endcase
    end

    assign lo_now  = burst_lo(start_now, step_now, q.order_f);
    assign is_rd   = op_now inside {bsp_pkg::OP_BEGIN_RD, bsp_pkg::OP_NEXT_RD,
                                    bsp_pkg::OP_HOLD_RD};
    assign is_wr   = op_now inside {bsp_pkg::OP_BEGIN_WR, bsp_pkg::OP_NEXT_WR,
                                    bsp_pkg::OP_HOLD_WR};
    assign rd_word = mem[{hi_now, lo_now}];

    // ------------------------------------------------------------
    // array write
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (ce && rst_n && is_wr) begin
            for (int l = 0; l < LANES; l++) begin
                if (lane_we[l]) begin
                    mem[{hi_now, lo_now}][l*LW +: LW] <= dq_i[l*LW +: LW];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d         = q;
        d.oe_s    = {q.oe_s[1:0], out_enable_n};
        d.sleep_s = {q.sleep_s[1:0], sleep_req};
        d.flow_s  = {q.flow_s[1:0], flowthru_sel_n};
        d.order_s = {q.order_s[1:0], linear_order_n};
        d.oe_f    = filt(q.oe_s, q.oe_f);
        d.sleep_f = filt(q.sleep_s, q.sleep_f);
        d.flow_f  = filt(q.flow_s, q.flow_f);
        d.order_f = filt(q.order_s, q.order_f);
        d.hi      = hi_now;
        d.start   = start_now;
        d.step    = step_now;
        d.lo      = lo_now;
        d.op      = op_now;
        d.pv      = is_rd;
        d.pdata   = rd_word;
        if (!q.flow_f) begin
            d.dq_o  = rd_word;
            d.dq_oe = {LANES{is_rd && !q.oe_f}};
        end else begin
            d.dq_o  = q.pdata;
            d.dq_oe = {LANES{q.pv && !q.oe_f && !sleep_eff}};
        end
        d.waitreq = !((avs_read || avs_write) && q.waitreq);
        if (avs_write && !q.waitreq && avs_address == bsp_pkg::OFS_CTRL) begin
            d.standby = avs_writedata[bsp_pkg::CTRL_STANDBY];
        end
        d.rdata = 32'h0;
        if (avs_address == bsp_pkg::OFS_CTRL) begin
            d.rdata[bsp_pkg::CTRL_STANDBY] = q.standby;
        end else if (avs_address == bsp_pkg::OFS_STATUS) begin
            d.rdata[bsp_pkg::ST_SLEEP]                  = sleep_eff;
            d.rdata[bsp_pkg::ST_PIPE]                   = q.flow_f;
            d.rdata[bsp_pkg::ST_INTLV]                  = q.order_f;
            d.rdata[bsp_pkg::ST_OP_LSB +: 3]            = q.op;
            d.rdata[bsp_pkg::ST_STEP_LSB +: 2]          = q.step;
            d.rdata[bsp_pkg::ST_LO_LSB +: 2]            = q.lo;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q         <= '0;
            q.oe_s    <= {3{bsp_pkg::RST_OUT_DIS}};
            q.oe_f    <= bsp_pkg::RST_OUT_DIS;
            q.sleep_s <= {3{bsp_pkg::RST_SLEEP}};
            q.sleep_f <= bsp_pkg::RST_SLEEP;
            q.flow_s  <= {3{bsp_pkg::RST_PIPE}};
            q.flow_f  <= bsp_pkg::RST_PIPE;
            q.order_s <= {3{bsp_pkg::RST_INTLV}};
            q.order_f <= bsp_pkg::RST_INTLV;
            q.standby <= bsp_pkg::RST_STANDBY;
            q.waitreq <= bsp_pkg::RST_WAITREQ;
        end else if (ce) begin
            q <= d;
        end
    end

    assign dq_o            = q.dq_o;
    assign dq_oe           = q.dq_oe;
    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = q.waitreq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_begin;
        ce && (op_now inside {bsp_pkg::OP_BEGIN_RD, bsp_pkg::OP_BEGIN_WR});
    endsequence
    sequence s_next;
        ce && (op_now inside {bsp_pkg::OP_NEXT_RD, bsp_pkg::OP_NEXT_WR});
    endsequence
    sequence s_pipe_rd;
        ce && is_rd && q.flow_f && !q.oe_f && !sleep_eff
        ##1 ce && q.flow_f && !q.oe_f && !sleep_eff;
    endsequence

    a_desel_decode: assert property (ce && desel && !sleep_eff
        |=> q.op == bsp_pkg::OP_DESEL)
        else $error("deselect not decoded");
    a_begin_load: assert property (s_begin
        |=> q.step == 2'h0 && q.start == $past(addr_low_bits))
        else $error("burst start not loaded");
    a_burst_wrap: assert property (s_begin ##1 s_next [*4]
        |=> q.lo == $past(q.lo, 4))
        else $error("burst did not wrap after four");
    a_hold_addr: assert property (ce && op_now == bsp_pkg::OP_HOLD_RD
        |=> q.step == $past(q.step) && q.hi == $past(q.hi))
        else $error("suspend moved address");
    a_flow_read: assert property (ce && is_rd && !q.flow_f && !q.oe_f
        |=> dq_oe == '1 && dq_o == $past(rd_word))
        else $error("flow read not driven");
    a_pipe_read: assert property (s_pipe_rd
        |=> dq_oe == '1 && dq_o == $past(rd_word, 2))
        else $error("pipeline read wrong");
    a_write_hiz: assert property (ce && is_wr && !q.flow_f
        |=> dq_oe == '0)
        else $error("lanes driven after write");
    a_pipe_write_hiz: assert property (ce && is_wr && q.flow_f ##1 ce && q.flow_f
        |=> dq_oe == '0)
        else $error("lanes driven after pipelined write");
    a_oe_off: assert property (ce && q.oe_f |=> dq_oe == '0)
        else $error("drivers on with output disabled");
    a_global_wr: assert property (is_wr && !all_bytes_write_n
        |-> lane_we == '1)
        else $error("global write missed lanes");
    a_sleep_idle: assert property (ce && sleep_eff
        |=> q.op == bsp_pkg::OP_NONE)
        else $error("command taken in standby");
    a_bus_wait: assert property (ce && (avs_read || avs_write) && q.waitreq
        |=> !avs_waitrequest)
        else $error("bus wait not released");

endmodule

/* test_burst_sram_port_logic.sv */
module test_burst_sram_port_logic;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 19;
    localparam int DW = 36;
    localparam int LW = DW / 4;
    logic          mclk = 1'b0;
    logic          arst_n = 1'b0;
    logic          ce = 1'b1;
    logic          out_enable_n = 1'b0;
    logic          sleep_req = 1'b0;
    logic          flowthru_sel_n = 1'b1;
    logic          linear_order_n = 1'b1;
    logic [3:0]    avs_address = 4'h0;
    logic          avs_read = 1'b0;
    logic          avs_write = 1'b0;
    logic [31:0]   avs_writedata = 32'h0;
    wire logic     sel1_n, sel2, sel3_n, ps_n, cs_n, step_n, all_n, gate_n, avs_waitrequest;
    wire logic [3:0]  lane_n, dq_oe;
    wire logic [AW-1:0] addr;
    wire logic [DW-1:0] wdata, dq_o;
    wire logic [31:0] avs_readdata;
    int            num_errors = 0, checks = 0, seed = 17856;
    int            op, base, start, step, lo, last_op, last_lo, a, s;
    bit            run, m_oe = 1, m_stby, m_pipe = 1, m_lin, pend_v, rd_v, exp_oe, wr, en;
    logic [DW-1:0] mem [0:63];
    logic [DW-1:0] rd_d, pend_d, exp_d;
    logic [31:0]   q;

    always #5 mclk = ~mclk;

    bsp_top u_bsp_top (
        .mclk, .arst_n, .ce, .chip_sel_one_n(sel1_n), .chip_sel_two(sel2),
        .chip_sel_three_n(sel3_n), .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(cs_n),
        .burst_step_n(step_n), .addr_high(addr[AW-1:2]), .addr_low_bits(addr[1:0]),
        .all_bytes_write_n(all_n), .lane_write_gate_n(gate_n), .byte_lane_a_n(lane_n[0]),
        .byte_lane_b_n(lane_n[1]), .byte_lane_c_n(lane_n[2]), .byte_lane_d_n(lane_n[3]),
        .out_enable_n, .sleep_req, .flowthru_sel_n, .linear_order_n, .dq_i(wdata), .dq_o,
        .dq_oe, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest
    );
    bsp_ctrl_model #(.AW(AW), .DW(DW)) u_bsp_ctrl_model (
        .mclk, .sel1_n, .sel2, .sel3_n, .ps_n, .cs_n, .step_n, .all_n, .gate_n, .lane_n,
        .addr, .wdata
    );

    // ----
    // tasks
    // ----
    task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] e);
        checks++;
        if (seen !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, e, seen);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches %0d of %0d checks", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic bus(input bit w, input logic [3:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= ad;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        check("wait states", DW'(n), DW'(2));
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic c(input int k, input bit w, input bit all, input logic [3:0] ln, input int ad);
        u_bsp_ctrl_model.cmd(k, w, all, ln, AW'(ad), DW'({$random(seed), $random(seed)}));
    endtask

    task automatic idle(input int n);
        repeat (n) c(0, 0, 0, 4'hf, 0);
    endtask

    // ----
    // behavioural model, evaluated on the sampling edge
    // ----
    always @(posedge mclk) begin
        if (run && ce) begin
            en = !sel1_n && sel2 && !sel3_n;
            wr = !all_n || !gate_n;
            rd_v = 0;
            if (m_stby) op = 0;
            else if ((!sel1_n && !en && (!ps_n || !cs_n)) || (sel1_n && !cs_n)) op = 1;
            else if (en && (!ps_n || !cs_n)) begin
                op = (!ps_n || !wr) ? 2 : 3;
                base = addr[AW-1:2];
                start = addr[1:0];
                step = 0;
            end else begin
                if (!step_n) step = (step + 1) % 4;
                op = (step_n ? 6 : 4) + int'(wr);
            end
            if (op > 1) begin
                lo = m_lin ? (start + step) % 4 : start ^ step;
                a = (base * 4 + lo) % 64;
                last_lo = lo;
                if (op % 2 == 1) begin
                    for (int l = 0; l < 4; l++)
                        if (!all_n || !lane_n[l]) mem[a][l*LW +: LW] = wdata[l*LW +: LW];
                end else begin
                    rd_v = 1;
                    rd_d = mem[a];
                end
            end
            last_op = op;
            exp_oe = m_pipe ? pend_v && m_oe : rd_v && m_oe;
            exp_d = m_pipe ? pend_d : rd_d;
            pend_v = rd_v;
            pend_d = rd_d;
        end
    end

    always @(negedge mclk) begin
        if (run) begin
            check("dq_oe", DW'(dq_oe), DW'({4{exp_oe}}));
            if (exp_oe) check("dq_o", dq_o, exp_d);
        end
    end

    // ----
    // main sequence
    // ----
    initial begin
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        run <= 1'b1;
        bus(0, bsp_pkg::OFS_CTRL, 0);
        check("ctrl reset", DW'(q[0]), DW'(bsp_pkg::RST_STANDBY));
        for (int i = 0; i < 8; i++) c(2, 1, 1, 4'h0, 32 + i);
        for (int m = 0; m < 4; m++) begin
            flowthru_sel_n <= (m < 2);
            linear_order_n <= !m[0];
            idle(8);
            m_pipe <= (m < 2);
            m_lin <= m[0];
            bus(0, bsp_pkg::OFS_STATUS, 0);
            check("status modes", DW'(q[2:1]), DW'({!m_lin, m_pipe}));
            s = $random(seed) & 3;
            c(2, 1, 1, 4'h0, 32 + s);
            repeat (3) c(3, 1, 0, 4'($random(seed)), 0);
            c(4, 1, 0, 4'($random(seed)), 0);
            c(1, 1, 1, 4'h0, 32 + s);
            repeat (4) c(3, 0, 0, 4'($random(seed)), 0);
            repeat (2) c(4, 0, 0, 4'hf, 0);
            // commands offered while the clock enable is low must be ignored
            ce <= 1'b0;
            repeat (3) c(3, 0, 0, 4'hf, 0);
            ce <= 1'b1;
            c(4, 0, 0, 4'hf, 0);
            bus(0, bsp_pkg::OFS_STATUS, 0);
            check("status op", DW'(q[5:3]), DW'(last_op));
            check("status step", DW'(q[7:6]), DW'(step));
            check("status low", DW'(q[9:8]), DW'(last_lo));
            c(5, 0, 0, 4'hf, 0);
            idle(2);
        end
        repeat (12) c(2, 1'($random(seed)), 1'($random(seed)), 4'($random(seed)),
                      32 + ($random(seed) & 7));
        idle(2);
        out_enable_n <= 1'b1;
        idle(8);
        m_oe <= 1'b0;
        c(2, 0, 0, 4'hf, 36);
        c(3, 0, 0, 4'hf, 0);
        c(3, 1, 1, 4'h0, 0);
        idle(1);
        out_enable_n <= 1'b0;
        idle(8);
        m_oe <= 1'b1;
        c(2, 0, 0, 4'hf, 38);
        idle(3);
        for (int j = 0; j < 2; j++) begin
            if (j == 0) bus(1, bsp_pkg::OFS_CTRL, 32'h1);
            else sleep_req <= 1'b1;
            idle(8);
            m_stby <= 1'b1;
            c(2, 1, 1, 4'h0, 33);
            idle(2);
            bus(0, bsp_pkg::OFS_STATUS, 0);
            check("status stby", DW'(q[5:0]), DW'({3'(last_op), !m_lin, m_pipe, 1'b1}));
            if (j == 0) bus(1, bsp_pkg::OFS_CTRL, 32'h0);
            else sleep_req <= 1'b0;
            idle(8);
            m_stby <= 1'b0;
            c(2, 0, 0, 4'hf, 33);
            idle(3);
        end
        bus(1, 4'h8, 32'hffff_ffff);
        bus(0, 4'h8, 0);
        check("unmapped", DW'(q), 0);
        end_of_test();
    end

    initial begin
        #200000;
        check("watchdog", 36'h1, 36'h0);
        end_of_test();
    end
endmodule
